// [lcdi_defines.vh]
`ifndef LCDI_DEFINES_VH
`define LCDI_DEFINES_VH

// Upper six bits of the slave address; the lsb comes from a pin
`define LCDI_SLAVE_ADDR_HI   6'h1D
`define LCDI_CTL_CONT_BIT    7
`define LCDI_CTL_RS_BIT      6
`define LCDI_RAM_DEPTH       80
`define LCDI_RAM_LAST        7'h4F
`define LCDI_ADDR_ZERO       7'h00
`define LCDI_OP_HOME_MASK    8'hFE
`define LCDI_OP_HOME         8'h02
`define LCDI_OP_SHIFT_MASK   8'hF0
`define LCDI_OP_SHIFT        8'h10
`define LCDI_SHIFT_DISP_BIT  3
`define LCDI_SHIFT_RIGHT_BIT 2
`define LCDI_OP_SETADDR_BIT  7
`define LCDI_DATA_REG_RST    8'h00
`define LCDI_FIFO_WIDTH      9
`define LCDI_FIFO_DEPTH      32
`define LCDI_FIFO_AW         5
`define LCDI_BITS_PER_BYTE   4'h8

`endif

// [lcdi_fifo.v]
`timescale 1ns/100ps
`default_nettype none

module lcdi_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             i_clk,
   input  wire             i_reset,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   reg [AW:0]      count_r;

   wire push = i_in_valid & o_in_ready;
   wire pop  = o_out_valid & i_out_ready;

   assign o_in_ready  = (count_r != DEPTH[AW:0]);
   assign o_out_valid = (count_r != {(AW+1){1'b0}});
   assign o_out_data  = mem[rd_ptr_r];

   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   // Pointers wrap naturally since depth is a power of two
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop) begin
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule

`default_nettype wire

// [lcdi_top.v]
// How it works
// RQ1: Home instruction loads address zero into the address counter.
// RQ2: Home also clears display shift; display RAM contents stay untouched.
// RQ3: Home leaves the data register exactly as it was.
// RQ4: Read address acknowledge copies the data register into the output shifter.
// RQ5: Data register counts as undefined until an address set or read loads it.
// RQ6: Master picks RAM target with register select while still writing.
// RQ7: Stream control byte with register select set makes reads return RAM.
// RQ8: Each read byte shifts out over eight clocks, msb first.
// RQ9: Master acknowledge loads next RAM location and advances the counter.
// RQ10: No acknowledge from master: nothing is loaded into the shifter.
// RQ11: No acknowledge: data register, counter and cursor stay unchanged.
// RQ12: Slave releases the data line during the read acknowledge phase.
// RQ13: Instructions start on the clock pulse of the following acknowledge; while i_exec_hold is high the code keeps them waiting in the FIFO.
// RQ14: RAM write stores the byte then advances the counter by one.
// RQ15: Answer only own address, lsb from pin; acknowledge written bytes; the code gives a data byte no acknowledge while the FIFO is full.
`timescale 1ns/100ps
`default_nettype none
`include "lcdi_defines.vh"

module lcdi_top (
   input  wire       i_clk,
   input  wire       i_reset,
   input  wire       i_scl,
   input  wire       i_sda_in,
   output reg        o_sda_out,
   output reg        o_sda_oe,
   input  wire       i_address_lsb_pin,
   input  wire       i_exec_hold,
   output reg  [6:0] o_addr_counter,
   output reg  [6:0] o_display_offset,
   output reg  [7:0] o_data_reg,
   output reg        o_data_reg_defined,
   output reg        o_write_pending
);

   localparam S_IDLE = 8'h01;
   localparam S_ADDR = 8'h02;
   localparam S_ACKA = 8'h04;
   localparam S_WR   = 8'h08;
   localparam S_ACKW = 8'h10;
   localparam S_RD   = 8'h20;
   localparam S_ACKR = 8'h40;
   localparam S_SKIP = 8'h80;

   reg [7:0] state_r;
   reg       scl_d_r;
   reg       sda_d_r;
   reg [7:0] shin_r;
   reg [7:0] shout_r;
   reg [3:0] cnt_r;
   reg       rd_dir_r;
   reg       expect_ctl_r;
   reg       cont_r;
   reg       rs_r;
   reg [6:0] ac_r;
   reg [6:0] ofs_r;
   reg [7:0] dreg_r;
   reg       dreg_ok_r;
   reg [7:0] ram [0:`LCDI_RAM_DEPTH-1];

   wire scl_rise = i_scl & ~scl_d_r;
   wire scl_fall = ~i_scl & scl_d_r;
   wire start    = scl_d_r & i_scl & sda_d_r & ~i_sda_in;
   wire stop     = scl_d_r & i_scl & ~sda_d_r & i_sda_in;

   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [8:0] fifo_out_data;
   wire       push = (state_r == S_ACKW) & scl_rise & ~expect_ctl_r;
   wire       pop  = fifo_out_valid & ~i_exec_hold;
   wire       op_rs = fifo_out_data[8];
   wire [7:0] op    = fifo_out_data[7:0];

   wire addr_match = (shin_r[7:2] == `LCDI_SLAVE_ADDR_HI) &
                     (shin_r[1] == i_address_lsb_pin); // RQ15
   // Reads wait for queued writes, so the refusal is a not-acknowledge
   wire addr_ok    = addr_match & (~shin_r[0] | ~fifo_out_valid);

   wire [6:0] ac_next  = (ac_r == `LCDI_RAM_LAST) ? `LCDI_ADDR_ZERO : ac_r + 7'h01;
   wire [7:0] rd_value = rs_r ? ram[ac_next] : {o_write_pending, ac_r}; // RQ7

   lcdi_fifo #(
      .WIDTH (`LCDI_FIFO_WIDTH),
      .DEPTH (`LCDI_FIFO_DEPTH),
      .AW    (`LCDI_FIFO_AW)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_in_valid  (push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({rs_r, shin_r}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (~i_exec_hold),
      .o_out_data  (fifo_out_data)
   );

   // Display RAM has no reset; its content is whatever software wrote
   always @(posedge i_clk) begin
      if (pop & op_rs) begin
         ram[ac_r] <= op; // RQ14
      end
   end

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_r            <= S_IDLE;
         scl_d_r            <= 1'b1;
         sda_d_r            <= 1'b1;
         shin_r             <= 8'h00;
         shout_r            <= 8'h00;
         cnt_r              <= 4'h0;
         rd_dir_r           <= 1'b0;
         expect_ctl_r       <= 1'b1;
         cont_r             <= 1'b0;
         rs_r               <= 1'b1;
         ac_r               <= `LCDI_ADDR_ZERO;
         ofs_r              <= `LCDI_ADDR_ZERO;
         dreg_r             <= `LCDI_DATA_REG_RST;
         dreg_ok_r          <= 1'b0;
         o_sda_out          <= 1'b0;
         o_sda_oe           <= 1'b0;
         o_addr_counter     <= `LCDI_ADDR_ZERO;
         o_display_offset   <= `LCDI_ADDR_ZERO;
         o_data_reg         <= `LCDI_DATA_REG_RST;
         o_data_reg_defined <= 1'b0;
         o_write_pending    <= 1'b0;
      end else begin
         scl_d_r            <= i_scl;
         sda_d_r            <= i_sda_in;
         o_sda_out          <= 1'b0;
         o_addr_counter     <= ac_r;
         o_display_offset   <= ofs_r;
         o_data_reg         <= dreg_r;
         o_data_reg_defined <= dreg_ok_r;
         o_write_pending    <= fifo_out_valid;

         // Queued instructions; the serial side is idle for reads meanwhile
         if (pop) begin
            if (op_rs) begin
               ac_r <= ac_next; // RQ14
            end else if (op[`LCDI_OP_SETADDR_BIT]) begin
               ac_r      <= op[6:0];
               dreg_r    <= ram[op[6:0]];
               dreg_ok_r <= 1'b1;
            end else if ((op & `LCDI_OP_HOME_MASK) == `LCDI_OP_HOME) begin
               ac_r  <= `LCDI_ADDR_ZERO; // RQ1
               ofs_r <= `LCDI_ADDR_ZERO; // RQ2 RQ3
            end else if ((op & `LCDI_OP_SHIFT_MASK) == `LCDI_OP_SHIFT) begin
               if (op[`LCDI_SHIFT_DISP_BIT]) begin
                  ofs_r <= op[`LCDI_SHIFT_RIGHT_BIT] ? ofs_r + 7'h01 : ofs_r - 7'h01;
               end
            end
         end

         if (start) begin
            state_r  <= S_ADDR;
            cnt_r    <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (stop) begin
            state_r  <= S_IDLE;
            o_sda_oe <= 1'b0;
         end else begin
            case (state_r)
               S_ADDR, S_WR: begin
                  if (scl_rise) begin
                     shin_r <= {shin_r[6:0], i_sda_in};
                     cnt_r  <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == `LCDI_BITS_PER_BYTE) begin
                     if (state_r == S_ADDR) begin
                        if (addr_ok) begin
                           o_sda_oe <= 1'b1; // RQ15
                           rd_dir_r <= shin_r[0];
                           state_r  <= S_ACKA;
                        end else begin
                           state_r <= S_SKIP;
                        end
                     end else if (expect_ctl_r | fifo_in_ready) begin
                        o_sda_oe <= 1'b1; // RQ15
                        state_r  <= S_ACKW;
                     end else begin
                        state_r <= S_SKIP;
                     end
                  end
               end
               S_ACKA: begin
                  if (scl_rise) begin
                     expect_ctl_r <= 1'b1;
                     if (rd_dir_r) begin
                        shout_r <= dreg_r; // RQ4 RQ5
                     end
                  end else if (scl_fall) begin
                     cnt_r    <= 4'h0;
                     o_sda_oe <= rd_dir_r & ~shout_r[7]; // RQ8
                     state_r  <= rd_dir_r ? S_RD : S_WR;
                  end
               end
               S_ACKW: begin
                  if (scl_rise) begin
                     if (expect_ctl_r) begin
                        cont_r       <= shin_r[`LCDI_CTL_CONT_BIT];
                        rs_r         <= shin_r[`LCDI_CTL_RS_BIT]; // RQ6 RQ7
                        expect_ctl_r <= 1'b0;
                     end else begin
                        expect_ctl_r <= cont_r; // RQ13
                     end
                  end else if (scl_fall) begin
                     cnt_r    <= 4'h0;
                     o_sda_oe <= 1'b0;
                     state_r  <= S_WR;
                  end
               end
               S_RD: begin
                  if (scl_rise) begin
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt_r == `LCDI_BITS_PER_BYTE) begin
                        o_sda_oe <= 1'b0; // RQ12
                        state_r  <= S_ACKR;
                     end else begin
                        shout_r  <= {shout_r[6:0], 1'b0};
                        o_sda_oe <= ~shout_r[6]; // RQ8
                     end
                  end
               end
               S_ACKR: begin
                  if (scl_rise) begin
                     if (!i_sda_in) begin
                        shout_r   <= rd_value; // RQ9
                        if (rs_r) begin
                           dreg_r    <= rd_value;
                           dreg_ok_r <= 1'b1;
                           ac_r      <= ac_next; // RQ9
                        end
                     end else begin
                        state_r <= S_SKIP; // RQ10 RQ11
                     end
                  end else if (scl_fall) begin
                     cnt_r    <= 4'h0;
                     o_sda_oe <= ~shout_r[7]; // RQ8
                     state_r  <= S_RD;
                  end
               end
               S_IDLE, S_SKIP: begin
                  o_sda_oe <= 1'b0;
               end
               default: begin
                  state_r  <= S_IDLE;
                  o_sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// [lcdi_top_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module lcdi_monitor (
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic       i_scl,
   input wire logic       i_exec_hold,
   input wire logic       o_sda_out,
   input wire logic       o_sda_oe,
   input wire logic [6:0] o_addr_counter,
   input wire logic [6:0] o_display_offset,
   input wire logic [7:0] o_data_reg,
   input wire logic       o_data_reg_defined,
   input wire logic       o_write_pending
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_scl_fell;
      $past(i_scl, 2) && !$past(i_scl);
   endsequence
   sequence s_oe_holds;
      $stable(o_sda_oe)[*3];
   endsequence
   a_out_low: assert property (o_sda_out == 1'b0)
      else $error("sda data level not low");
   a_oe_after_fall: assert property ($changed(o_sda_oe) |-> s_scl_fell)
      else $error("sda drive changed away from an scl fall");
   a_oe_holds: assert property ($changed(o_sda_oe) |=> s_oe_holds)
      else $error("sda drive did not hold");
   a_ac_range: assert property (o_addr_counter <= 7'h4F)
      else $error("address counter beyond last ram cell");
   a_offset_step: assert property ($changed(o_display_offset) |->
      (o_display_offset == 7'h00 || o_display_offset - $past(o_display_offset) == 7'h01
       || $past(o_display_offset) - o_display_offset == 7'h01))
      else $error("display offset jumped");
   a_reg_defined: assert property ($changed(o_data_reg) |-> o_data_reg_defined)
      else $error("data register changed without a load");
   a_def_sticky: assert property (o_data_reg_defined |=> o_data_reg_defined)
      else $error("defined flag dropped");
   a_hold_freezes: assert property ($past(i_exec_hold) && $past(i_exec_hold, 2)
      && o_write_pending |-> $stable(o_addr_counter))
      else $error("counter moved while executor held");
endmodule
bind lcdi_top lcdi_monitor lcdi_monitor_i (.i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl),
   .i_exec_hold(i_exec_hold), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_addr_counter(o_addr_counter), .o_display_offset(o_display_offset),
   .o_data_reg(o_data_reg), .o_data_reg_defined(o_data_reg_defined),
   .o_write_pending(o_write_pending));
`default_nettype wire

// [lcdi_master.sv]
`timescale 1ns/100ps
`default_nettype none
module lcdi_master (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_pull
);
   initial o_scl = 1'b1;
   initial o_pull = 1'b0;
   task automatic q;
      repeat (4) @(posedge i_clk);
      #1;
   endtask
   // Data moves only while SCL low
   task automatic bit_c(input logic pull, output logic seen);
      o_pull = pull;
      q();
      o_scl = 1'b1;
      q();
      seen = i_sda;
      o_scl = 1'b0;
      q();
   endtask
   task automatic start_c;
      o_pull = 1'b1;
      q();
      o_scl = 1'b0;
      q();
   endtask
   task automatic stop_c;
      o_pull = 1'b1;
      q();
      o_scl = 1'b1;
      q();
      o_pull = 1'b0;
      q();
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_c(~b[i], s);
      bit_c(1'b0, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic s;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         bit_c(1'b0, s);
         d = {d[6:0], s};
      end
      bit_c(ack, s);
   endtask
endmodule
`default_nettype wire

// [lcd_i2c_read_access_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lcdi_defines.vh"
module lcd_i2c_read_access_bench;
   logic       i_clk = 1'b0;
   logic       i_reset = 1'b1;
   logic       pin = 1'b0;
   logic       hold = 1'b0;
   logic       scl;
   logic       pull;
   logic       sda_out;
   logic       sda_oe;
   logic [6:0] ac;
   logic [6:0] offset;
   logic [7:0] dreg;
   logic       defined;
   logic       pending;
   int         n_errors = 0;
   int         comparisons = 0;
   // Pull-up: released line reads high
   wire        sda = ~(pull | sda_oe);
   always #50 i_clk = ~i_clk;
   lcdi_top lcdi_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda_in(sda),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_address_lsb_pin(pin), .i_exec_hold(hold),
      .o_addr_counter(ac), .o_display_offset(offset), .o_data_reg(dreg),
      .o_data_reg_defined(defined), .o_write_pending(pending));
   lcdi_master lcdi_master_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic settle;
      for (int k = 0; k < 300 && pending !== 1'b0; k++) @(posedge i_clk);
      repeat (4) @(posedge i_clk);
      #1;
      check("drained", 8'h00, {7'h00, pending});
   endtask
   task automatic wr(input logic [7:0] b);
      logic a;
      lcdi_master_i.wbyte(b, a);
      check("ack", 8'h01, {7'h00, a});
   endtask
   task automatic t_fill;
      logic a;
      hold = 1'b1;
      lcdi_master_i.start_c();
      wr(8'h74);
      wr(8'h40);
      for (int i = 0; i <= `LCDI_FIFO_DEPTH; i++) begin
         lcdi_master_i.wbyte(8'h41 + i[7:0], a);
         check("fill ack", {7'h00, i < `LCDI_FIFO_DEPTH}, {7'h00, a});
      end
      check("pending", 8'h01, {7'h00, pending});
      lcdi_master_i.stop_c();
      hold = 1'b0;
      settle();
      check("fill ac", 8'h20, {1'b0, ac});
      $display("fill test done");
   endtask
   task automatic t_addr;
      logic a;
      pin = 1'b1;
      lcdi_master_i.start_c();
      lcdi_master_i.wbyte(8'h74, a);
      check("foreign ack", 8'h00, {7'h00, a});
      lcdi_master_i.stop_c();
      lcdi_master_i.start_c();
      wr(8'h76);
      lcdi_master_i.stop_c();
      pin = 1'b0;
      $display("address test done");
   endtask
   task automatic t_home;
      lcdi_master_i.start_c();
      wr(8'h74);
      wr(8'h80);
      wr(8'h1C);
      wr(8'h80);
      check("shifted", 8'h01, {1'b0, offset});
      wr(8'h02);
      lcdi_master_i.stop_c();
      settle();
      check("home ac", 8'h00, {1'b0, ac});
      check("home offset", 8'h00, {1'b0, offset});
      check("home dreg", `LCDI_DATA_REG_RST, dreg);
      check("undefined", 8'h00, {7'h00, defined});
      $display("home test done");
   endtask
   task automatic t_read;
      logic       a;
      logic [7:0] d;
      lcdi_master_i.start_c();
      wr(8'h74);
      wr(8'h40);
      lcdi_master_i.stop_c();
      lcdi_master_i.start_c();
      lcdi_master_i.wbyte(8'h75, a);
      check("read ack", 8'h01, {7'h00, a});
      lcdi_master_i.rbyte(1'b1, d);
      check("preload", `LCDI_DATA_REG_RST, d);
      lcdi_master_i.rbyte(1'b1, d);
      check("byte one", 8'h42, d);
      lcdi_master_i.rbyte(1'b0, d);
      check("byte two", 8'h43, d);
      check("idle drive", 8'h00, {7'h00, sda_oe});
      lcdi_master_i.stop_c();
      settle();
      check("read ac", 8'h02, {1'b0, ac});
      check("read dreg", 8'h43, dreg);
      check("defined", 8'h01, {7'h00, defined});
      $display("read test done");
   endtask
   task automatic t_keep;
      logic       a;
      logic [7:0] d;
      lcdi_master_i.start_c();
      wr(8'h74);
      wr(8'h00);
      wr(8'h85);
      wr(8'h02);
      wr(8'h18);
      lcdi_master_i.stop_c();
      settle();
      check("kept ac", 8'h00, {1'b0, ac});
      check("kept dreg", 8'h46, dreg);
      check("left shift", 8'h7F, {1'b0, offset});
      // A queued write must turn the read address away
      hold = 1'b1;
      lcdi_master_i.start_c();
      wr(8'h74);
      wr(8'hC0);
      wr(8'h5A);
      wr(8'h00);
      lcdi_master_i.stop_c();
      lcdi_master_i.start_c();
      lcdi_master_i.wbyte(8'h75, a);
      check("busy read", 8'h00, {7'h00, a});
      lcdi_master_i.stop_c();
      check("queued", 8'h01, {7'h00, pending});
      hold = 1'b0;
      settle();
      check("one write", 8'h01, {1'b0, ac});
      lcdi_master_i.start_c();
      wr(8'h75);
      lcdi_master_i.rbyte(1'b1, d);
      check("set preload", 8'h46, d);
      lcdi_master_i.rbyte(1'b0, d);
      check("status read", 8'h01, d);
      lcdi_master_i.stop_c();
      settle();
      check("status ac", 8'h01, {1'b0, ac});
      check("status dreg", 8'h46, dreg);
      $display("keep test done");
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      #1;
      i_reset = 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      t_fill();
      t_addr();
      t_home();
      t_read();
      t_keep();
      complete_run();
   end
   // Tests need about 7000 cycles; allow more than twice that
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
